// File: hw/sca_defs.svh
/*
 * Register offsets, field positions and reset values of the shared and
 * channel register access block.
 * Assumes inclusion by bare name from files under hw/.
 */
`ifndef SCA_DEFS_SVH
`define SCA_DEFS_SVH

// shared register offsets
`define SCA_OFS_STRAP      8'h00
`define SCA_OFS_IDENT      8'h01
`define SCA_OFS_RSV2       8'h02
`define SCA_OFS_RSV3       8'h03
`define SCA_OFS_CTRL       8'h04
`define SCA_OFS_STAT       8'h05
`define SCA_OFS_RSV6       8'h06
`define SCA_OFS_RSV7       8'h07
`define SCA_OFS_SELECT     8'hFF

// control register fields
`define SCA_BIT_SHREG_RST  6
`define SCA_BIT_MAS_RST    5
`define SCA_BIT_FORCE_LOAD 4

// status register fields
`define SCA_BIT_CFG_DIS    7
`define SCA_BIT_LOAD_DONE  4

// select register fields
`define SCA_BIT_BCAST      3
`define SCA_BIT_CHSET_EN   2

// reset values
`define SCA_RST_CTRL       8'h01
`define SCA_RST_STAT_HI    3'h0
`define SCA_RST_LOAD_DONE  1'h1
`define SCA_RST_RSV2       8'h00
`define SCA_RST_RSV6       8'h00
`define SCA_RST_RSV7       8'h05
`define SCA_RST_CHAN       8'h00

// bus address base, read answer of the select register
`define SCA_ADDR_BASE      7'h18
`define SCA_INVALID_READ   8'h00

`endif

// File: hw/sca_pkg.sv
/*
 * Types of the shared and channel register access block.
 * Assumes nothing of its surroundings.
 */
package sca_pkg;

    typedef enum logic [1:0] {
        TGT_SHARED,
        TGT_SINGLE,
        TGT_BROADCAST
    } sca_target_t;

endpackage

// File: hw/sca_chan_store.sv
/*
 * One channel register set: byte-wide flip-flop storage with one write
 * port and one combinational read port.
 * Assumes a synchronised active-low reset and one clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sca_defs.svh"

module sca_chan_store #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    import sca_pkg::*;

    logic [7:0] mem      [DEPTH];
    logic [7:0] next_mem [DEPTH];

    always_comb begin
        next_mem = mem;
        if (wrEn) begin
            next_mem[addr] = wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `SCA_RST_CHAN;
            end
        end else begin
            mem <= next_mem;
        end
    end

    assign rdata = mem[addr];

endmodule
`default_nettype wire

// File: hw/sca_reg_access.sv
/*
 * Register access for a four-lane retimer: shared register set, four
 * lane register sets, the select register that steers host accesses.
 * Assumes a decoded host byte port (one-cycle read/write strobes with
 * address and data), an outside configuration loader and lane events.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sca_defs.svh"

// Function
// - one shared register set plus an independent register set per lane
// - writes to the select address always update the select register
// - with lane-set enable clear, reads and writes go to shared set
// - with enable set, other addresses go to the lane chosen by index
// - enable and broadcast both set: writes update all four lane sets
// - writes to read-only fields are ignored
// - strap value reads at bits 7:4 of offset 0; address is base plus strap
// - shared reset bit restores shared defaults, then clears itself
// - bus master reset bit resets the loader, then clears itself
// - force-load bit starts a configuration load from EEPROM
// - configuration disable bit blocks loading from EEPROM
// - read-only load-done bit set when the configuration load completes
// - four read-only lane interrupt flags, lane 0 at bit 3 to lane 3 at bit 0
// - lane reads use the indexed lane even when broadcasting
module sca_reg_access #(
    parameter int         LANES    = 4,
    parameter int         DEPTH    = 256,
    parameter logic [7:0] IDENTITY = 8'h5A  // arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] strapAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic            regRvalid,
    input  wire logic [3:0] laneIrq,
    input  wire logic       cfgLoadDone,
    output logic            cfgLoadStart,
    output logic            busMasterReset,
    output logic      [6:0] busAddress
);
    import sca_pkg::*;

    localparam logic [7:0] CtrlReset = `SCA_RST_CTRL;

    // reset release
    logic [1:0] rstPipe;
    logic [1:0] next_rstPipe;
    logic       rstn;

    always_comb begin
        next_rstPipe = {rstPipe[0], 1'b1};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= next_rstPipe;
        end
    end

    assign rstn = rstPipe[1];

    // shared state
    logic       selEn,       next_selEn;
    logic       selBcast,    next_selBcast;
    logic [1:0] selLane,     next_selLane;
    logic [7:0] ctrlReg,     next_ctrlReg;
    logic [2:0] statHi,      next_statHi;
    logic       loadDone,    next_loadDone;
    logic [3:0] irqFlags,    next_irqFlags;
    logic [7:0] rsv2,        next_rsv2;
    logic [7:0] rsv6,        next_rsv6;
    logic [7:0] rsv7,        next_rsv7;
    logic [3:0] strapReg,    next_strapReg;
    logic       strapCaught, next_strapCaught;
    logic [6:0] next_busAddress;
    logic       next_cfgLoadStart;
    logic [7:0] next_regRdata;
    logic       next_regRvalid;

    // access decode
    sca_target_t target;
    logic        isSelect;
    logic        shWr;
    logic        chWr;
    logic [3:0]  laneWe;
    logic [7:0]  laneRdata [LANES];
    logic [7:0]  laneRdataSel;
    logic        cfgDisable;

    assign isSelect     = (regAddr == `SCA_OFS_SELECT);
    assign target       = !selEn ? TGT_SHARED : (selBcast ? TGT_BROADCAST : TGT_SINGLE);
    assign shWr         = regWrite && !isSelect && (target == TGT_SHARED);
    assign chWr         = regWrite && !isSelect && (target != TGT_SHARED);
    assign laneRdataSel = laneRdata[selLane];
    assign cfgDisable   = statHi[2];

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            laneWe[i] = chWr && ((target == TGT_BROADCAST) || (selLane == i[1:0]));
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : gLane
        sca_chan_store #(
            .DEPTH (DEPTH),
            .AW    (8)
        ) uStore (
            .clk   (clk),
            .rstn  (rstn),
            .wrEn  (laneWe[g]),
            .addr  (regAddr),
            .wdata (regWdata),
            .rdata (laneRdata[g])
        );
    end

    // shared register next values
    always_comb begin
        next_selEn        = selEn;
        next_selBcast     = selBcast;
        next_selLane      = selLane;
        next_ctrlReg      = ctrlReg;
        next_statHi       = statHi;
        next_loadDone     = loadDone;
        next_irqFlags     = irqFlags;
        next_rsv2         = rsv2;
        next_rsv6         = rsv6;
        next_rsv7         = rsv7;
        next_strapReg     = strapReg;
        next_strapCaught  = 1'b1;
        next_busAddress   = busAddress;
        next_cfgLoadStart = 1'b0;

        // strap caught once after reset release
        if (!strapCaught) begin
            next_strapReg   = strapAddr;
            next_busAddress = `SCA_ADDR_BASE + {3'h0, strapAddr};
        end

        // self-clearing bits last one cycle
        next_ctrlReg[`SCA_BIT_MAS_RST] = 1'b0;
        if (ctrlReg[`SCA_BIT_SHREG_RST]) begin
            next_selEn    = 1'b0;
            next_selBcast = 1'b0;
            next_selLane  = 2'h0;
            next_ctrlReg  = CtrlReset;
            next_statHi   = `SCA_RST_STAT_HI;
            next_loadDone = `SCA_RST_LOAD_DONE;
            next_irqFlags = 4'h0;
            next_rsv2     = `SCA_RST_RSV2;
            next_rsv6     = `SCA_RST_RSV6;
            next_rsv7     = `SCA_RST_RSV7;
        end

        // lane interrupt flags are cleared by a shared read of the status register
        if (regRead && (target == TGT_SHARED) && (regAddr == `SCA_OFS_STAT)) begin
            next_irqFlags = 4'h0;
        end

        if (regWrite && isSelect) begin
            next_selBcast = regWdata[`SCA_BIT_BCAST];
            next_selEn    = regWdata[`SCA_BIT_CHSET_EN];
            next_selLane  = regWdata[1:0];
        end

        // read-only offsets fall to the default branch
        if (shWr) begin
            unique case (regAddr)
                `SCA_OFS_RSV2: next_rsv2 = regWdata;
                `SCA_OFS_RSV6: next_rsv6 = regWdata;
                `SCA_OFS_RSV7: next_rsv7 = regWdata;
                `SCA_OFS_STAT: next_statHi = regWdata[7:5];
                `SCA_OFS_CTRL: begin
                    next_ctrlReg = regWdata;
                    if (regWdata[`SCA_BIT_FORCE_LOAD] && !ctrlReg[`SCA_BIT_FORCE_LOAD]
                        && !cfgDisable) begin
                        next_cfgLoadStart = 1'b1;
                        next_loadDone     = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // hardware set wins over any clear
        next_irqFlags = next_irqFlags | {laneIrq[0], laneIrq[1], laneIrq[2], laneIrq[3]};
        if (cfgLoadDone) begin
            next_loadDone = 1'b1;
        end
    end

    // read answer
    always_comb begin
        next_regRvalid = regRead;
        next_regRdata  = regRdata;
        if (regRead) begin
            if (isSelect) begin
                next_regRdata = `SCA_INVALID_READ;
            end else if (target != TGT_SHARED) begin
                next_regRdata = laneRdataSel;
            end else begin
                unique case (regAddr)
                    `SCA_OFS_STRAP: next_regRdata = {strapReg, 4'h0};
                    `SCA_OFS_IDENT: next_regRdata = IDENTITY;
                    `SCA_OFS_RSV2:  next_regRdata = rsv2;
                    `SCA_OFS_CTRL:  next_regRdata = ctrlReg;
                    `SCA_OFS_STAT:  next_regRdata = {statHi, loadDone, irqFlags};
                    `SCA_OFS_RSV6:  next_regRdata = rsv6;
                    `SCA_OFS_RSV7:  next_regRdata = rsv7;
                    default:        next_regRdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            selEn          <= 1'b0;
            selBcast       <= 1'b0;
            selLane        <= 2'h0;
            ctrlReg        <= `SCA_RST_CTRL;
            statHi         <= `SCA_RST_STAT_HI;
            loadDone       <= `SCA_RST_LOAD_DONE;
            irqFlags       <= 4'h0;
            rsv2           <= `SCA_RST_RSV2;
            rsv6           <= `SCA_RST_RSV6;
            rsv7           <= `SCA_RST_RSV7;
            strapReg       <= 4'h0;
            strapCaught    <= 1'b0;
            busAddress     <= `SCA_ADDR_BASE;
            cfgLoadStart   <= 1'b0;
            regRdata       <= 8'h00;
            regRvalid      <= 1'b0;
        end else begin
            selEn          <= next_selEn;
            selBcast       <= next_selBcast;
            selLane        <= next_selLane;
            ctrlReg        <= next_ctrlReg;
            statHi         <= next_statHi;
            loadDone       <= next_loadDone;
            irqFlags       <= next_irqFlags;
            rsv2           <= next_rsv2;
            rsv6           <= next_rsv6;
            rsv7           <= next_rsv7;
            strapReg       <= next_strapReg;
            strapCaught    <= next_strapCaught;
            busAddress     <= next_busAddress;
            cfgLoadStart   <= next_cfgLoadStart;
            regRdata       <= next_regRdata;
            regRvalid      <= next_regRvalid;
        end
    end

    assign busMasterReset = ctrlReg[`SCA_BIT_MAS_RST];

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence shCtrlWrite(int b);
        shWr && (regAddr == `SCA_OFS_CTRL) && regWdata[b];
    endsequence

    sequence scPulse(int b);
        ctrlReg[b] ##1 !ctrlReg[b];
    endsequence

    selectWrite_a: assert property (regWrite && isSelect |=>
        selEn == $past(regWdata[2]) && selBcast == $past(regWdata[3])
        && selLane == $past(regWdata[1:0]))
        else $error("select register not updated");

    sharedRoute_a: assert property (regWrite && !selEn |-> laneWe == 4'h0)
        else $error("lane written while shared set selected");

    laneRoute_a: assert property (chWr && !selBcast |-> laneWe == (4'h1 << selLane))
        else $error("wrong lane written");

    bcastWrite_a: assert property (regWrite && !isSelect && selEn && selBcast
        |-> laneWe == 4'hF)
        else $error("broadcast did not write all lanes");

    readOnly_a: assert property (shWr && (regAddr == `SCA_OFS_STRAP)
        && strapCaught |=> $stable(strapReg))
        else $error("read-only field changed by write");

    strapAddr_a: assert property (strapCaught |->
        busAddress == `SCA_ADDR_BASE + {3'h0, strapReg})
        else $error("bus address differs from base plus strap");

    softReset_a: assert property (shCtrlWrite(`SCA_BIT_SHREG_RST)
        |=> scPulse(`SCA_BIT_SHREG_RST) ##0 (rsv7 == `SCA_RST_RSV7) && !selEn)
        else $error("shared reset did not restore defaults");

    masterReset_a: assert property (shCtrlWrite(`SCA_BIT_MAS_RST)
        |=> busMasterReset ##1 !busMasterReset)
        else $error("bus master reset not a single pulse");

    forceLoad_a: assert property (shCtrlWrite(`SCA_BIT_FORCE_LOAD)
        ##0 (!ctrlReg[`SCA_BIT_FORCE_LOAD] && !cfgDisable && !cfgLoadDone)
        |=> cfgLoadStart && !loadDone)
        else $error("force load did not start loading");

    cfgDisable_a: assert property (cfgLoadStart |-> !$past(cfgDisable))
        else $error("load started while disabled");

    loadDone_a: assert property (cfgLoadDone |=> loadDone)
        else $error("load done not set");

    irqFlag_a: assert property (laneIrq[0] |=> irqFlags[3])
        else $error("lane 0 interrupt flag not set");

    irqFlagLast_a: assert property (laneIrq[3] |=> irqFlags[0])
        else $error("lane 3 interrupt flag not set");

    laneRead_a: assert property (regRead && !isSelect && selEn
        |=> regRvalid && regRdata == $past(laneRdataSel))
        else $error("lane read from wrong lane");

endmodule
`default_nettype wire

// File: test/sca_host_model.sv
/*
 * Host side of the register byte port: single-byte writes and reads.
 * Assumes its tasks are called from the bench at a falling clock edge.
 */
`timescale 1ns/100ps
`default_nettype none

module sca_host_model (
    input  wire logic       clk,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata
);
    initial begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // whole-byte writes to documented places only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr  = a;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
        regAddr  = ~a;
        regWdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRead = 1'b0;
        regAddr = ~a;
    endtask

    // select written whole, upper nibble zero
    task automatic sel(input logic [3:0] v);
        wr(8'hFF, {4'h0, v});
    endtask
endmodule

`default_nettype wire

// File: test/tb_top.sv
/*
 * Self-checking bench of the register access block.
 * Assumes the host model drives the byte port; the bench drives events.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam logic [7:0] ID_VAL = 8'h3C;  // arbitrary value
    logic       clk = 1'b0;
    logic       resetn;
    logic [3:0] strap;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic       regRvalid;
    logic [3:0] laneIrq;
    logic       cfgLoadDone;
    logic       cfgLoadStart;
    logic       busMasterReset;
    logic [6:0] busAddress;
    logic [7:0] expQ[$];
    logic [7:0] laneVal[4];
    logic [7:0] v;
    logic [3:0] p;
    logic [3:0] rev;
    int         errorCnt = 0;
    int         checked = 0;

    always #25 clk = ~clk;

    sca_reg_access #(.IDENTITY(ID_VAL)) DUT (
        .clk(clk), .resetn(resetn), .strapAddr(strap), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regRvalid(regRvalid), .laneIrq(laneIrq),
        .cfgLoadDone(cfgLoadDone), .cfgLoadStart(cfgLoadStart),
        .busMasterReset(busMasterReset), .busAddress(busAddress)
    );

    sca_host_model host (
        .clk(clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata)
    );

    task automatic cmpData(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errorCnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmpPin(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            errorCnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.rd(a);
    endtask

    task automatic note(input string s);
        repeat (2) @(negedge clk);
        $display("test %s done", s);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // read answers against the oldest note
    always @(negedge clk) begin
        if (regRvalid === 1'b1) begin
            if (expQ.size() == 0) begin
                errorCnt++;
                $display("ERROR t=%0t exp=none got=%h", $time, regRdata);
            end else begin
                cmpData(expQ.pop_front(), regRdata);
            end
        end
    end

    initial begin
        #(50 * 5000);
        errorCnt++;
        complete_run();
    end

    initial begin
        void'($urandom(77253));
        strap = 4'($urandom());
        resetn = 1'b0;
        laneIrq = 4'h0;
        cfgLoadDone = 1'b0;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        cmpPin({1'b0, busAddress}, {1'b0, 7'h18 + {3'h0, strap}});
        rd(8'h00, {strap, 4'h0});
        rd(8'h01, ID_VAL);
        rd(8'h04, 8'h01);
        rd(8'h05, 8'h10);
        rd(8'h07, 8'h05);
        rd(8'hFF, 8'h00);
        note("reset values");
        v = 8'($urandom());
        host.wr(8'h00, v);
        host.wr(8'h01, v);
        host.wr(8'h03, v);
        host.wr(8'h05, 8'h6F);
        host.wr(8'h02, v);
        rd(8'h00, {strap, 4'h0});
        rd(8'h01, ID_VAL);
        rd(8'h03, 8'h00);
        rd(8'h05, 8'h70);
        rd(8'h02, v);
        note("read-only places");
        for (int i = 0; i < 4; i++) begin
            laneVal[i] = 8'($urandom());
            host.sel(4'(4 + i));
            host.wr(8'h00, laneVal[i]);
        end
        for (int i = 0; i < 4; i++) begin
            host.sel(4'(4 + i));
            rd(8'h00, laneVal[i]);
        end
        host.sel(4'h0);
        rd(8'h00, {strap, 4'h0});
        note("lane routing");
        v = 8'($urandom());
        host.sel(4'hC);
        host.wr(8'h30, v);
        host.sel(4'h6);
        host.wr(8'h30, ~v);
        for (int i = 0; i < 4; i++) begin
            host.sel(4'(12 + i));
            rd(8'h30, (i == 2) ? ~v : v);
        end
        host.sel(4'h0);
        note("broadcast");
        p = 4'($urandom()) | 4'h9;
        @(negedge clk);
        laneIrq = p;
        @(negedge clk);
        laneIrq = 4'h0;
        for (int i = 0; i < 4; i++) begin
            rev[3 - i] = p[i];
        end
        rd(8'h05, {4'h7, rev});
        rd(8'h05, 8'h70);
        note("lane flags");
        host.wr(8'h04, 8'h11);
        cmpPin({7'h00, cfgLoadStart}, 8'h01);
        @(negedge clk);
        cmpPin({7'h00, cfgLoadStart}, 8'h00);
        rd(8'h05, 8'h60);
        @(negedge clk);
        cfgLoadDone = 1'b1;
        @(negedge clk);
        cfgLoadDone = 1'b0;
        rd(8'h05, 8'h70);
        host.wr(8'h04, 8'h01);
        host.wr(8'h05, 8'hE0);
        host.wr(8'h04, 8'h11);
        cmpPin({7'h00, cfgLoadStart}, 8'h00);
        rd(8'h05, 8'hF0);
        note("config load");
        host.wr(8'h04, 8'h31);
        cmpPin({7'h00, busMasterReset}, 8'h01);
        rd(8'h04, 8'h11);
        host.wr(8'h02, 8'hA5);
        host.wr(8'h04, 8'h41);
        repeat (2) @(negedge clk);
        rd(8'h04, 8'h01);
        rd(8'h02, 8'h00);
        rd(8'h05, 8'h10);
        rd(8'h07, 8'h05);
        cmpPin({1'b0, busAddress}, {1'b0, 7'h18 + {3'h0, strap}});
        host.sel(4'h5);
        rd(8'h00, laneVal[1]);
        note("soft resets");
        @(negedge clk);
        resetn = 1'b0;
        strap = 4'($urandom());
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        cmpPin({1'b0, busAddress}, {1'b0, 7'h18 + {3'h0, strap}});
        rd(8'h00, {strap, 4'h0});
        rd(8'h05, 8'h10);
        host.sel(4'h5);
        rd(8'h00, 8'h00);
        note("mid-run reset");
        cmpPin(8'(expQ.size()), 8'h00);
        complete_run();
    end
endmodule

`default_nettype wire
